/* File: core/ccdsr_pkg.sv */
/*
  ccdsr_pkg: constants, types and the default parameter image for the
  system parameter group of the ccd timing generator.
  Assumes the burst words arrive already deserialised, 32 bits at a time.
*/
package ccdsr_pkg;

  // burst framing
  localparam int             WORD_W       = 32;
  localparam int             NUM_WORDS    = 16;
  localparam int             IMG_W        = WORD_W * NUM_WORDS;
  localparam int             IDX_W        = 5;
  localparam int             HDR_ADDR_MSB = 31;
  localparam int             HDR_ADDR_LSB = 24;
  localparam int             HDR_CNT_W    = 24;
  localparam logic [7:0]     GROUP_ADDR   = 8'h14;
  localparam logic [23:0]    COUNT_ALL    = 24'h000000;

  // field widths
  localparam int VLEN_W = 9;
  localparam int VTOG_W = 9;
  localparam int PHASES = 4;
  localparam int NSEQ   = 4;
  localparam int BLK_W  = 10;
  localparam int LINE_W = 12;
  localparam int INT2_W = 10;
  localparam int INT3_W = 9;
  localparam int INT4_W = 9;
  localparam int SHUT_W = 8;
  localparam int GTOG_W = 11;
  localparam int GWID_W = 8;
  localparam int SUB_W  = 9;
  localparam int CLP_W  = 12;
  localparam int VSY_W  = 4;
  localparam int HSY_W  = 10;

  // msb positions inside the concatenated image, word 1 bit 31 = IMG_W-1
  localparam int P_VSEQ0     = 511;
  localparam int P_VSEQ3     = 255;
  localparam int VSEQ_STRIDE = 85;
  localparam int OFF_POL     = 9;
  localparam int OFF_TOG     = 13;
  localparam int TOG_STRIDE  = 18;
  localparam int P_BLANK = 170;
  localparam int P_LINE  = 159;
  localparam int P_INT2  = 147;
  localparam int P_INT3  = 137;
  localparam int P_INT4  = 128;
  localparam int P_SHUT  = 119;
  localparam int P_GATE0 = 111;
  localparam int P_GATE1 = 100;
  localparam int P_GWID0 = 89;
  localparam int P_SUB1A = 81;
  localparam int P_SUB1B = 72;
  localparam int P_SUB2A = 63;
  localparam int P_SUB2B = 54;
  localparam int P_CLP1  = 45;
  localparam int P_CLP2  = 33;
  localparam int P_VSYNC = 21;
  localparam int P_HSYNC = 17;
  localparam int P_GAP_A = 256;
  localparam int P_GAP_B = 160;
  localparam int GAP_TAIL_W = 8;
  localparam logic [IMG_W-1:0] UNUSED_MASK = (IMG_W'(1) << P_GAP_A) | (IMG_W'(1) << P_GAP_B)
                                           | IMG_W'({GAP_TAIL_W{1'b1}});

  // reset values
  localparam logic [VLEN_W-1:0] DEF_LEN [NSEQ] = '{9'h025, 9'h068, 9'h039, 9'h059};
  localparam logic [PHASES-1:0] DEF_POL = 4'hc;
  localparam logic [VTOG_W-1:0] DEF_TOG [NSEQ][PHASES][2] = '{
    '{'{9'h000, 9'h013}, '{9'h00c, 9'h01f}, '{9'h000, 9'h013}, '{9'h00c, 9'h01f}},
    '{'{9'h012, 9'h03a}, '{9'h02f, 9'h060}, '{9'h000, 9'h04c}, '{9'h026, 9'h069}},
    '{'{9'h000, 9'h01d}, '{9'h013, 9'h030}, '{9'h000, 9'h01d}, '{9'h013, 9'h030}},
    '{'{9'h000, 9'h03c}, '{9'h01e, 9'h05a}, '{9'h000, 9'h03c}, '{9'h01e, 9'h05a}}};
  localparam logic [LINE_W-1:0] DEF_LINE  = 12'h8eb;
  localparam logic [INT2_W-1:0] DEF_INT2  = 10'h082;
  localparam logic [INT3_W-1:0] DEF_INT3  = 9'h064;
  localparam logic [SHUT_W-1:0] DEF_SHUT  = 8'h76;
  localparam logic [GTOG_W-1:0] DEF_GATE0 = 11'h418;
  localparam logic [GTOG_W-1:0] DEF_GATE1 = 11'h4ae;
  localparam logic [GWID_W-1:0] DEF_GWID0 = 8'h3c;
  localparam logic [SUB_W-1:0]  DEF_SUBA  = 9'h013;
  localparam logic [SUB_W-1:0]  DEF_SUBB  = 9'h058;
  localparam logic [CLP_W-1:0]  DEF_CLP1  = 12'h8c3;
  localparam logic [CLP_W-1:0]  DEF_CLP2  = 12'h8e6;
  localparam logic [VSY_W-1:0]  DEF_VSYNC = 4'h9;
  localparam logic [HSY_W-1:0]  DEF_HSYNC = 10'h078;
  localparam logic              SUB_IDLE   = 1'b1;
  localparam logic              CLAMP_IDLE = 1'b1;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_LOAD = 3'h2,
    ST_SKIP = 3'h4
  } ccdsr_state_type;

  typedef struct packed {
    logic [VLEN_W-1:0]              repeatLength;
    logic [PHASES-1:0]              startPolarity;
    logic [PHASES-1:0][VTOG_W-1:0]  firstToggle;
    logic [PHASES-1:0][VTOG_W-1:0]  secondToggle;
  } ccdsr_vseq_type;

  typedef struct packed {
    ccdsr_vseq_type [NSEQ-1:0]      vseq;
    logic [BLK_W-1:0]               blankHclkOnPosition;
    logic [LINE_W-1:0]              lineLengthCount;
    logic [INT2_W-1:0]              secondIntervalCount;
    logic [INT3_W-1:0]              thirdIntervalCount;
    logic [INT4_W-1:0]              fourthIntervalCount;
    logic [SHUT_W-1:0]              shutterSequenceLength;
    logic [1:0][GTOG_W-1:0]         sensorGateToggle;
    logic [GWID_W-1:0]              sensorGate0Width;
    logic [1:0][SUB_W-1:0]          substrateToggle1;
    logic [1:0][SUB_W-1:0]          substrateToggle2;
    logic [CLP_W-1:0]               blackClampToggle1;
    logic [CLP_W-1:0]               blackClampToggle2;
    logic [VSY_W-1:0]               vsyncTogglePosition;
    logic [HSY_W-1:0]               hsyncTogglePosition;
  } ccdsr_params_type;

  // msb of vertical sequence s; sequence 3 sits past a spare bit
  function automatic int vseqMsb(input int s);
    return (s == NSEQ - 1) ? P_VSEQ3 : P_VSEQ0 - s * VSEQ_STRIDE;
  endfunction

  function automatic int togMsb(input int s, input int ph, input int t);
    return vseqMsb(s) - OFF_TOG - TOG_STRIDE * ph - VTOG_W * t;
  endfunction

  // raw image holding every reset value at its burst position
  function automatic logic [IMG_W-1:0] defImage();
    logic [IMG_W-1:0] img;
    img = '0;
    for (int s = 0; s < NSEQ; s++) begin
      img[vseqMsb(s) -: VLEN_W] = DEF_LEN[s];
      for (int ph = 0; ph < PHASES; ph++) begin
        img[vseqMsb(s) - OFF_POL - ph] = DEF_POL[ph];
        img[togMsb(s, ph, 0) -: VTOG_W] = DEF_TOG[s][ph][0];
        img[togMsb(s, ph, 1) -: VTOG_W] = DEF_TOG[s][ph][1];
      end
    end
    img[P_LINE -: LINE_W]  = DEF_LINE;
    img[P_INT2 -: INT2_W]  = DEF_INT2;
    img[P_INT3 -: INT3_W]  = DEF_INT3;
    img[P_SHUT -: SHUT_W]  = DEF_SHUT;
    img[P_GATE0 -: GTOG_W] = DEF_GATE0;
    img[P_GATE1 -: GTOG_W] = DEF_GATE1;
    img[P_GWID0 -: GWID_W] = DEF_GWID0;
    img[P_SUB1A -: SUB_W]  = DEF_SUBA;
    img[P_SUB1B -: SUB_W]  = DEF_SUBB;
    img[P_SUB2A -: SUB_W]  = DEF_SUBA;
    img[P_SUB2B -: SUB_W]  = DEF_SUBB;
    img[P_CLP1 -: CLP_W]   = DEF_CLP1;
    img[P_CLP2 -: CLP_W]   = DEF_CLP2;
    img[P_VSYNC -: VSY_W]  = DEF_VSYNC;
    img[P_HSYNC -: HSY_W]  = DEF_HSYNC;
    return img;
  endfunction

endpackage

/* File: core/ccdsr_toggle_out.sv */
/*
  ccdsr_toggle_out: one waveform output that starts a repetition at a
  programmed level and inverts at two programmed positions.
  Assumes the caller supplies a position counter and a restart at position 0.
*/
`timescale 1ns/10ps
module ccdsr_toggle_out
  import ccdsr_pkg::*;
#(
  parameter int POS_W = 9
) (
  input  wire logic             clock,
  input  wire logic             arst_n,
  input  wire logic             run,
  input  wire logic             restart,
  input  wire logic             startLevel,
  input  wire logic [POS_W-1:0] pos,
  input  wire logic [POS_W-1:0] toggleA,
  input  wire logic [POS_W-1:0] toggleB,
  input  wire logic             idleLevel,
  output logic                  level
);

  logic hit;
  logic level_d;

  // both toggles on one position cancel, as two inversions would
  assign hit     = (pos == toggleA) ^ (pos == toggleB);
  assign level_d = !run    ? level :
                   restart ? startLevel ^ hit : level ^ hit;

  // output lags the position by one clock
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      level <= 1'b0;
    end else begin
      level <= level_d;
    end
  end

  logic unusedIdle;
  assign unusedIdle = idleLevel;

endmodule

/* File: core/ccdsr_system_timing_regs.sv */
/*
  ccdsr_system_timing_regs: the system parameter group of the ccd timing
  generator, loaded as one burst of 32-bit words, plus the vertical phase,
  substrate clock and black clamp waveforms driven from it.
  Assumes the serial front end delivers whole words with wordValid and holds
  burstActive high for the whole burst; vertical sync is synchronous.
*/
// Operation
// RULE1 - header top byte 0x14 selects this group
// RULE2 - header low 24 bits count; zero means all
// RULE3 - four sequences with 9-bit repeat lengths
// RULE4 - per-phase start polarity, phases three/four high
// RULE5 - phase starts at polarity, inverts at toggles
// RULE6 - fields straddling words are concatenated
// RULE7 - 10-bit blank hclk on position, default 0
// RULE8 - 12-bit line length is gray coded
// RULE9 - second and third interval counters stored
// RULE10 - fourth interval straddles words, default 0
// RULE11 - 8-bit shutter sequence length, default 118
// RULE12 - two gate toggles and first width
// RULE13 - substrate clocks invert at both toggles
// RULE14 - clamp toggles gray coded, second straddles
// RULE15 - vsync 4-bit and hsync 10-bit toggles
// RULE16 - new values apply at vsync fall unless immediate
// RULE17 - unused burst bits are ignored
`timescale 1ns/10ps
module ccdsr_system_timing_regs
  import ccdsr_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              arst_n,
  input  wire logic              burstActive,
  input  wire logic              wordValid,
  input  wire logic [WORD_W-1:0] wordData,
  input  wire logic              verticalSync,
  input  wire logic              updateModeBit,
  input  wire logic              vseqRun,
  input  wire logic [1:0]        vseqSelect,
  input  wire logic              lineRun,
  output ccdsr_params_type       params,
  output logic [PHASES-1:0]      verticalPhase,
  output logic [1:0]             substrateClk,
  output logic                   opticalBlackClamp,
  output logic                   updatePending,
  output logic                   groupLoading
);

  // gray code to binary, used for every gray-coded field
  function automatic logic [LINE_W-1:0] grayToBin(input logic [LINE_W-1:0] g);
    logic [LINE_W-1:0] b;
    b[LINE_W-1] = g[LINE_W-1];
    for (int i = LINE_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  // image to parameter set; the image is the burst words laid end to end
  function automatic ccdsr_params_type unpackImage(input logic [IMG_W-1:0] img);
    ccdsr_params_type p;
    p = '0;
    for (int s = 0; s < NSEQ; s++) begin
      p.vseq[s].repeatLength = img[vseqMsb(s) -: VLEN_W];                  // [RULE3]
      for (int ph = 0; ph < PHASES; ph++) begin
        p.vseq[s].startPolarity[ph] = img[vseqMsb(s) - OFF_POL - ph];      // [RULE4]
        p.vseq[s].firstToggle[ph]   = img[togMsb(s, ph, 0) -: VTOG_W];     // [RULE6]
        p.vseq[s].secondToggle[ph]  = img[togMsb(s, ph, 1) -: VTOG_W];
      end
    end
    p.blankHclkOnPosition   = img[P_BLANK -: BLK_W];                       // [RULE7]
    p.lineLengthCount       = grayToBin(img[P_LINE -: LINE_W]);            // [RULE8]
    p.secondIntervalCount   = img[P_INT2 -: INT2_W];                       // [RULE9]
    p.thirdIntervalCount    = img[P_INT3 -: INT3_W];                       // [RULE9]
    p.fourthIntervalCount   = img[P_INT4 -: INT4_W];                       // [RULE10]
    p.shutterSequenceLength = img[P_SHUT -: SHUT_W];                       // [RULE11]
    p.sensorGateToggle[0]   = img[P_GATE0 -: GTOG_W];                      // [RULE12]
    p.sensorGateToggle[1]   = img[P_GATE1 -: GTOG_W];                      // [RULE12]
    p.sensorGate0Width      = img[P_GWID0 -: GWID_W];                      // [RULE12]
    p.substrateToggle1[0]   = img[P_SUB1A -: SUB_W];                       // [RULE13]
    p.substrateToggle2[0]   = img[P_SUB1B -: SUB_W];
    p.substrateToggle1[1]   = img[P_SUB2A -: SUB_W];
    p.substrateToggle2[1]   = img[P_SUB2B -: SUB_W];
    p.blackClampToggle1     = grayToBin(img[P_CLP1 -: CLP_W]);             // [RULE14]
    p.blackClampToggle2     = grayToBin(img[P_CLP2 -: CLP_W]);             // [RULE14]
    p.vsyncTogglePosition   = img[P_VSYNC -: VSY_W];                       // [RULE15]
    p.hsyncTogglePosition   = img[P_HSYNC -: HSY_W];                       // [RULE15]
    return p;
  endfunction

  localparam logic [IMG_W-1:0] RESET_IMG    = defImage();
  localparam ccdsr_params_type RESET_PARAMS = unpackImage(defImage());

  ccdsr_state_type        state_q, state_d;
  logic [HDR_CNT_W-1:0]   remaining_q, remaining_d;
  logic [IDX_W-1:0]       wordIdx_q, wordIdx_d;
  logic [IMG_W-1:0]       pendingImg_q, pendingImg_d;
  logic                   dirty_q, dirty_d;
  logic                   vsyncPrev_q;
  ccdsr_params_type       params_d;
  logic                   loading_d;
  logic [VLEN_W-1:0]      vseqPos_q, vseqPos_d;
  logic [LINE_W-1:0]      linePos_q, linePos_d;

  // header decode
  logic                 headerSeen;
  logic                 headerMatch;
  logic [HDR_CNT_W-1:0] headerCount;
  logic [HDR_CNT_W-1:0] wordsToLoad;
  logic                 loadWord;
  logic                 lastWord;

  assign headerSeen  = wordValid && (state_q == ST_IDLE);
  assign headerMatch = wordData[HDR_ADDR_MSB:HDR_ADDR_LSB] == GROUP_ADDR;            // [RULE1]
  assign headerCount = wordData[HDR_CNT_W-1:0];
  assign wordsToLoad = (headerCount == COUNT_ALL) ? HDR_CNT_W'(NUM_WORDS)           // [RULE2]
                                                  : headerCount;
  assign loadWord    = wordValid && (state_q == ST_LOAD);
  // a count above the group size stops at the last word of the group
  assign lastWord    = (remaining_q == HDR_CNT_W'(1)) || (wordIdx_q == IDX_W'(NUM_WORDS));

  // burst sequencer; dropping burstActive always returns to idle
  always_comb begin
    state_d     = state_q;
    remaining_d = remaining_q;
    wordIdx_d   = wordIdx_q;
    case (state_q)
      ST_IDLE: begin
        if (headerSeen) begin
          state_d     = headerMatch ? ST_LOAD : ST_SKIP;                             // [RULE1]
          remaining_d = wordsToLoad;
          wordIdx_d   = IDX_W'(1);
        end
      end
      ST_LOAD: begin
        if (loadWord) begin
          remaining_d = remaining_q - HDR_CNT_W'(1);
          wordIdx_d   = wordIdx_q + IDX_W'(1);
          if (lastWord) begin
            state_d = ST_SKIP;
          end
        end
      end
      ST_SKIP: begin
        state_d = ST_SKIP;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    if (!burstActive) begin
      state_d = ST_IDLE;
    end
  end

  assign loading_d = (state_d == ST_LOAD);

  // word placement: word k lands at the k-th slot from the top of the image,
  // so a field split across two words reads back as one contiguous field
  logic [9:0]       wordBase;
  logic [IMG_W-1:0] writeMask;
  logic [IMG_W-1:0] writeData;

  assign wordBase     = 10'(IMG_W - WORD_W * int'(wordIdx_q));                      // [RULE6]
  assign writeMask    = IMG_W'({WORD_W{1'b1}}) << wordBase;
  assign writeData    = IMG_W'(wordData) << wordBase;
  assign pendingImg_d = loadWord ? ((pendingImg_q & ~writeMask)
                                    | (writeData & writeMask & ~UNUSED_MASK))        // [RULE17]
                                 : pendingImg_q;

  // update timing: synchronous parameters wait for a vsync falling edge
  logic vsyncFall;
  logic applyNow;

  assign vsyncFall = vsyncPrev_q && !verticalSync;
  assign applyNow  = dirty_q && (updateModeBit || vsyncFall);                       // [RULE16]
  // a word taken in the apply cycle keeps the pending flag set
  assign dirty_d   = loadWord || (dirty_q && !applyNow);
  assign params_d  = applyNow ? unpackImage(pendingImg_q) : params;

  // vertical sequence repetition counter
  ccdsr_vseq_type selSeq;
  logic           vseqRestart;

  assign selSeq      = params.vseq[vseqSelect];
  assign vseqRestart = vseqRun && (vseqPos_q == '0);
  assign vseqPos_d   = !vseqRun ? '0 :
                       (vseqPos_q >= selSeq.repeatLength - VLEN_W'(1)) ? '0        // [RULE3]
                                                                       : vseqPos_q + VLEN_W'(1);

  // line position counter for substrate and clamp waveforms
  logic lineRestart;

  assign lineRestart = lineRun && (linePos_q == '0);
  assign linePos_d   = !lineRun ? '0 :
                       (linePos_q >= params.lineLengthCount - LINE_W'(1)) ? '0
                                                                          : linePos_q + LINE_W'(1);

  // burst and update state
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_q      <= ST_IDLE;
      remaining_q  <= '0;
      wordIdx_q    <= '0;
      pendingImg_q <= RESET_IMG;
      dirty_q      <= 1'b0;
      vsyncPrev_q  <= 1'b0;
      groupLoading <= 1'b0;
    end else begin
      state_q      <= state_d;
      remaining_q  <= remaining_d;
      wordIdx_q    <= wordIdx_d;
      pendingImg_q <= pendingImg_d;
      dirty_q      <= dirty_d;
      vsyncPrev_q  <= verticalSync;
      groupLoading <= loading_d;
    end
  end

  // active parameters and counters
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      params    <= RESET_PARAMS;
      vseqPos_q <= '0;
      linePos_q <= '0;
    end else begin
      params    <= params_d;
      vseqPos_q <= vseqPos_d;
      linePos_q <= linePos_d;
    end
  end

  assign updatePending = dirty_q;

  // the four vertical phases of the selected sequence
  for (genvar ph = 0; ph < PHASES; ph++) begin : gPhase
    ccdsr_toggle_out #(.POS_W(VLEN_W)) uPhase (                                      // [RULE5]
      .clock      (clock),
      .arst_n     (arst_n),
      .run        (vseqRun),
      .restart    (vseqRestart),
      .startLevel (selSeq.startPolarity[ph]),
      .pos        (vseqPos_q),
      .toggleA    (selSeq.firstToggle[ph]),
      .toggleB    (selSeq.secondToggle[ph]),
      .idleLevel  (1'b0),
      .level      (verticalPhase[ph])
    );
  end

  // both substrate clock patterns run on the line position
  for (genvar k = 0; k < 2; k++) begin : gSub
    ccdsr_toggle_out #(.POS_W(LINE_W)) uSub (                                        // [RULE13]
      .clock      (clock),
      .arst_n     (arst_n),
      .run        (lineRun),
      .restart    (lineRestart),
      .startLevel (SUB_IDLE),
      .pos        (linePos_q),
      .toggleA    (LINE_W'(params.substrateToggle1[k])),
      .toggleB    (LINE_W'(params.substrateToggle2[k])),
      .idleLevel  (SUB_IDLE),
      .level      (substrateClk[k])
    );
  end

  // optical black clamp on binary-decoded toggle positions
  ccdsr_toggle_out #(.POS_W(LINE_W)) uClamp (                                        // [RULE14]
    .clock      (clock),
    .arst_n     (arst_n),
    .run        (lineRun),
    .restart    (lineRestart),
    .startLevel (CLAMP_IDLE),
    .pos        (linePos_q),
    .toggleA    (params.blackClampToggle1),
    .toggleB    (params.blackClampToggle2),
    .idleLevel  (CLAMP_IDLE),
    .level      (opticalBlackClamp)
  );

  // checks next to the logic they guard
  a_foreign_group: assert property (@(posedge clock) disable iff (!arst_n)  // [RULE1]
    (headerSeen && burstActive && !headerMatch) |=> (state_q == ST_SKIP) && !groupLoading)
    else $error("foreign group header was not skipped");

  a_count_all: assert property (@(posedge clock) disable iff (!arst_n)  // [RULE2]
    (headerSeen && burstActive && headerMatch && headerCount == COUNT_ALL)
    |=> remaining_q == HDR_CNT_W'(NUM_WORDS))
    else $error("zero count did not select the whole group");

  a_word_place: assert property (@(posedge clock) disable iff (!arst_n)  // [RULE6]
    (loadWord && wordIdx_q == IDX_W'(1))
    |=> pendingImg_q[IMG_W-1 -: WORD_W] == $past(wordData))
    else $error("first parameter word not placed at the image top");

  a_unused_bits: assert property (@(posedge clock) disable iff (!arst_n)  // [RULE17]
    (pendingImg_q & UNUSED_MASK) == '0)
    else $error("unused burst bit reached the parameter image");

  a_sync_hold: assert property (@(posedge clock) disable iff (!arst_n)  // [RULE16]
    (!updateModeBit && !vsyncFall) |=> $stable(params))
    else $error("synchronous parameters changed without a vsync fall");

  a_immediate: assert property (@(posedge clock) disable iff (!arst_n)  // [RULE16]
    (loadWord && lastWord && updateModeBit) ##1 updateModeBit
    |=> !updatePending && (params == unpackImage($past(pendingImg_q))))
    else $error("immediate update did not apply in two cycles");

  a_line_gray: assert property (@(posedge clock) disable iff (!arst_n)  // [RULE8]
    applyNow |=> params.lineLengthCount == grayToBin($past(pendingImg_q[P_LINE -: LINE_W])))
    else $error("line length not gray decoded on apply");

  a_repeat_wrap: assert property (@(posedge clock) disable iff (!arst_n)  // [RULE3]
    (vseqRun && vseqPos_q == selSeq.repeatLength - VLEN_W'(1)) |=> vseqPos_q == '0)
    else $error("vertical sequence did not wrap at its repeat length");

  a_phase_start: assert property (@(posedge clock) disable iff (!arst_n)  // [RULE5]
    (vseqRestart && selSeq.firstToggle[0] != '0 && selSeq.secondToggle[0] != '0)
    |=> verticalPhase[0] == $past(selSeq.startPolarity[0]))
    else $error("phase one did not start at its start polarity");

  a_sub_invert: assert property (@(posedge clock) disable iff (!arst_n)  // [RULE13]
    (lineRun && !lineRestart && linePos_q == LINE_W'(params.substrateToggle1[0])
     && params.substrateToggle1[0] != params.substrateToggle2[0])
    |=> substrateClk[0] != $past(substrateClk[0]))
    else $error("substrate clock did not invert at its toggle");

endmodule

/* File: testbench/ccdsr_host_model.sv */
/*
  ccdsr_host_model: host side of the parameter burst, one word per clock.
  Assumes the bench calls sendBurst and the group sits right behind it.
*/
`timescale 1ns/10ps
module ccdsr_host_model
  import ccdsr_pkg::*;
(
  input  wire logic        clock,
  output logic             burstActive,
  output logic             wordValid,
  output logic [WORD_W-1:0] wordData
);
  initial begin
    burstActive = 1'b0;
    wordValid = 1'b0;
    wordData = '0;
  end
  // header first, then image words; the line is scrambled once released
  task automatic sendBurst(input logic [7:0] grp, input logic [23:0] cnt,
                           input logic [IMG_W-1:0] img, input int n);
    @(posedge clock);
    burstActive <= 1'b1;
    wordValid <= 1'b1;
    wordData <= {grp, cnt};
    for (int k = 0; k < n; k++) begin
      @(posedge clock);
      wordData <= img[IMG_W-1-WORD_W*k -: WORD_W];
    end
    @(posedge clock);
    burstActive <= 1'b0;
    wordValid <= 1'b0;
    wordData <= ~wordData;
    @(posedge clock); // idle gap between bursts
  endtask
endmodule

/* File: testbench/ccdsr_system_timing_regs_tb_top.sv */
/*
  ccdsr_system_timing_regs_tb_top: self-checking bench for the parameter group.
  Assumes immediate update unless a case says otherwise; waveforms run on sequence 1 from the wave checks on.
*/
`timescale 1ns/10ps
module ccdsr_system_timing_regs_tb_top
  import ccdsr_pkg::*;
;
  typedef struct packed {logic [31:0] word; logic [8:0] len; logic [3:0] pol;} ccdsr_row_type;
  logic             clock = 1'b0;
  logic             arst_n = 1'b0;
  logic             verticalSync = 1'b0;
  logic             updateModeBit = 1'b1;
  logic             vseqRun = 1'b0;
  logic             lineRun = 1'b0;
  logic [1:0]       vseqSelect = 2'h0;
  logic             burstActive, wordValid, updatePending, groupLoading, opticalBlackClamp;
  logic [3:0]       verticalPhase;
  logic [1:0]       substrateClk;
  logic [6:0]       wave;
  logic [31:0]      wordData;
  ccdsr_params_type params;
  logic [IMG_W-1:0] img;
  int               bad_count = 0;
  int               tests_run = 0;
  logic [31:0]      defLen [4] = '{32'h25, 32'h68, 32'h39, 32'h59};
  ccdsr_row_type    rows [3] = '{'{{9'h12c, 4'h5, 19'h0}, 9'h12c, 4'ha},
    '{{9'h1ff, 4'hf, 19'h7ffff}, 9'h1ff, 4'hf}, '{{9'h001, 4'h8, 19'h0}, 9'h001, 4'h1}};

  always #12.5 clock = ~clock;

  // all waveform outputs in one word for the waveform checks
  assign wave = {verticalPhase, substrateClk, opticalBlackClamp};

  ccdsr_host_model ccdsr_host_model_inst (.clock(clock), .burstActive(burstActive),
    .wordValid(wordValid), .wordData(wordData));
  ccdsr_system_timing_regs ccdsr_system_timing_regs_inst (.clock(clock), .arst_n(arst_n),
    .burstActive(burstActive), .wordValid(wordValid), .wordData(wordData),
    .verticalSync(verticalSync), .updateModeBit(updateModeBit), .vseqRun(vseqRun),
    .vseqSelect(vseqSelect), .lineRun(lineRun), .params(params),
    .verticalPhase(verticalPhase), .substrateClk(substrateClk),
    .opticalBlackClamp(opticalBlackClamp), .updatePending(updatePending),
    .groupLoading(groupLoading));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // a hung handshake must not stall the run
  initial begin
    repeat (2000) @(posedge clock);
    bad_count++;
    give_verdict();
  end

  initial begin
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    #1;
    foreach (defLen[s]) check("len", 32'(params.vseq[s].repeatLength), defLen[s]);
    check("pol", 32'(params.vseq[2].startPolarity), 32'hc);
    // gray defaults read back decoded: 8eb gives f4d, 8c3 gives f7d
    check("a", {params.lineLengthCount, params.shutterSequenceLength}, 32'hf4d76);
    check("b", {params.blackClampToggle1, params.hsyncTogglePosition}, 32'h3df478);
    check("c", {params.secondIntervalCount, params.sensorGate0Width}, 32'h823c);
    // sequence 1 defaults: phase one inverts at 18, phase three at 0, phase four
    // stays high; substrate starts high and inverts at 19; clamp toggles lie later
    @(posedge clock);
    vseqSelect <= 2'h1;
    vseqRun <= 1'b1;
    lineRun <= 1'b1;
    repeat (18) @(posedge clock);
    #1;
    check("wave a", 32'(wave), 32'h47);
    repeat (2) @(posedge clock);
    #1;
    check("wave b", 32'(wave), 32'h49);
    foreach (rows[r]) begin
      ccdsr_host_model_inst.sendBurst(GROUP_ADDR, 24'h000001, {rows[r].word, 480'h0}, 1);
      repeat (2) @(posedge clock);
      #1;
      check("row len", 32'(params.vseq[0].repeatLength), 32'(rows[r].len));
      check("row pol", 32'(params.vseq[0].startPolarity), 32'(rows[r].pol));
    end
    check("kept", 32'(params.vseq[1].repeatLength), 32'h68);
    // deferred update waits for the sync falling edge
    @(posedge clock);
    updateModeBit <= 1'b0;
    ccdsr_host_model_inst.sendBurst(GROUP_ADDR, 24'h000001, {9'h04d, 23'h0, 480'h0}, 1);
    #1;
    check("held", {updatePending, groupLoading, 21'h0, params.vseq[0].repeatLength},
          32'h80000001);
    @(posedge clock);
    verticalSync <= 1'b1;
    @(posedge clock);
    verticalSync <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
    check("apply", {updatePending, 22'h0, params.vseq[0].repeatLength}, 32'h4d);
    @(posedge clock);
    updateModeBit <= 1'b1;
    ccdsr_host_model_inst.sendBurst(8'h15, 24'h000001, {9'h00b, 23'h0, 480'h0}, 1);
    repeat (2) @(posedge clock);
    #1;
    check("foreign", 32'(params.vseq[0].repeatLength), 32'h4d);
    // full burst: straddling, gray and unused bits
    img = '0;
    img[128:120] = 9'h105;
    img[159 -: 12] = 12'h5dc ^ 12'h2ee;
    img[33 -: 12] = 12'h7d0 ^ 12'h3e8;
    img[256] = 1'b1;
    img[7:0] = 8'hff;
    ccdsr_host_model_inst.sendBurst(GROUP_ADDR, COUNT_ALL, img, 16);
    repeat (2) @(posedge clock);
    #1;
    check("fourth", 32'(params.fourthIntervalCount), 32'h105);
    check("gray", {params.lineLengthCount, params.blackClampToggle2}, 32'h5dc7d0);
    check("unused", {params.hsyncTogglePosition, params.vseq[3].repeatLength}, 32'h0);
    check("all", 32'(params.vseq[0].repeatLength), 32'h0);
    give_verdict();
  end
endmodule
